// File: verilog/accm_regs.vh
// Purpose: register indices, field positions, reset values and state codes
// Assumes: byte address = 4 * index, 8-bit data in the low lane
// Notes:   definitions only
`ifndef ACCM_REGS_VH
`define ACCM_REGS_VH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define ACCM_IDX_XMSB   8'h00
`define ACCM_IDX_XLSB   8'h01
`define ACCM_IDX_YMSB   8'h02
`define ACCM_IDX_YLSB   8'h03
`define ACCM_IDX_ZMSB   8'h04
`define ACCM_IDX_ZLSB   8'h05
`define ACCM_IDX_STAT   8'h0b
`define ACCM_IDX_RANGE  8'h0e
`define ACCM_IDX_SLPTO  8'h29
`define ACCM_IDX_CTRL1  8'h2a
`define ACCM_IDX_CTRL2  8'h2b

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACCM_RUN_BIT    0
`define ACCM_FREAD_BIT  1
`define ACCM_QUIET_BIT  2
`define ACCM_SLPEN_BIT  2
`define ACCM_STEN_BIT   7

// ----------------------------------------------------------------
// full-scale codes and limits
// ----------------------------------------------------------------
`define ACCM_FS_2G      2'h0
`define ACCM_FS_4G      2'h1
`define ACCM_FS_8G      2'h2
`define ACCM_QUIET_MAX  17'h00fff
`define ACCM_QUIET_MIN  17'h1f000
`define ACCM_OUT_MAX    17'h007ff
`define ACCM_OUT_MIN    17'h1f800

// ----------------------------------------------------------------
// reset values and mode codes
// ----------------------------------------------------------------
`define ACCM_SLPTO_RST  8'h10
`define ACCM_CTRL1_RST  3'h0
`define ACCM_RANGE_RST  2'h0
`define ACCM_ST_OFF     2'h0
`define ACCM_ST_STBY    2'h1
`define ACCM_ST_WAKE    2'h2
`define ACCM_ST_SLEEP   2'h3

`endif

// File: verilog/accm_axis_fmt.v
// Purpose: one axis: self-test sum, quiet-mode limit, full-scale scaling
// Assumes: inputs in units of 1/1024 g, two's complement
// Notes:   combinational, result registered by the caller
`timescale 1ns/1ps
`default_nettype none
`include "accm_regs.vh"

module accm_axis_fmt
(
    input  wire [15:0] accelIn,
    input  wire [15:0] stimIn,
    input  wire        selfTest,
    input  wire        quiet,
    input  wire [1:0]  rangeSel,
    output reg  [11:0] countOut
);

    reg [16:0] sumVal;
    reg [16:0] limVal;
    reg [16:0] scaled;

    // ----------------------------------------------------------------
    // sum, limit, scale, saturate
    // ----------------------------------------------------------------
    always @*
    begin
        sumVal = {accelIn[15], accelIn};
        if (selfTest)
        begin
            sumVal = sumVal + {stimIn[15], stimIn};
        end
        limVal = sumVal;
        if (quiet && !limVal[16] && (limVal > `ACCM_QUIET_MAX))
        begin
            limVal = `ACCM_QUIET_MAX;
        end
        if (quiet && limVal[16] && (limVal < `ACCM_QUIET_MIN))
        begin
            limVal = `ACCM_QUIET_MIN;
        end
        case (rangeSel)
            `ACCM_FS_4G: scaled = {limVal[16], limVal[16:1]};
            `ACCM_FS_8G: scaled = {{2{limVal[16]}}, limVal[16:2]};
            default:     scaled = limVal;
        endcase
        if (!scaled[16] && (scaled > `ACCM_OUT_MAX))
        begin
            scaled = `ACCM_OUT_MAX;
        end
        else if (scaled[16] && (scaled < `ACCM_OUT_MIN))
        begin
            scaled = `ACCM_OUT_MIN;
        end
        countOut = scaled[11:0];
    end

endmodule
`default_nettype wire

// File: verilog/accm_mode_ctrl.v
// Purpose: mode control, sampling and output registers of a 3-axis sensor
// Assumes: Avalon-MM slave, one wait state, converter data on clk
// Notes:   powerGood is a pin and is synchronised
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "accm_regs.vh"

module accm_mode_ctrl
#(
    parameter [15:0] WAKE_DIV  = 16'd2000,
    parameter [15:0] SLEEP_DIV = 16'd16000
)
(
    input  wire        clk,
    input  wire        reset_n,
    input  wire [9:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    input  wire        powerGood,
    input  wire [15:0] accelX,
    input  wire [15:0] accelY,
    input  wire [15:0] accelZ,
    input  wire [15:0] stimX,
    input  wire [15:0] stimY,
    input  wire [15:0] stimZ,
    input  wire        wakeEvent,
    output wire        analogEn,
    output wire        sampleClkEn,
    output wire        selfTestEn,
    output wire [1:0]  modeState
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg  [1:0]  rstPipe_reg;
    wire        rstN;
    reg         pgMeta_reg;
    reg         pgSync_reg;
    reg         ack_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [2:0]  ctrl1_reg;
    reg         slpEn_reg;
    reg         stEn_reg;
    reg  [1:0]  range_reg;
    reg  [7:0]  slpTo_reg;
    reg  [7:0]  idle_reg;
    reg  [15:0] div_reg;
    reg  [11:0] outData_reg [0:2];
    wire [47:0] accelBus;
    wire [47:0] stimBus;
    wire [35:0] fmtBus;
    wire [7:0]  regIdx;
    wire        wrEn;
    wire        active;
    wire        enterActive;
    wire        tick;
    wire [15:0] divLimit;
    integer     i;

    assign regIdx   = address[9:2];
    assign accelBus = {accelZ, accelY, accelX};
    assign stimBus  = {stimZ, stimY, stimX};

    // ----------------------------------------------------------------
    // reset and power synchronisers
    // ----------------------------------------------------------------
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstPipe_reg <= 2'h0;
        end
        else
        begin
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
        end
    end
    assign rstN = rstPipe_reg[1];

    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            pgMeta_reg <= 1'b0;
            pgSync_reg <= 1'b0;
        end
        else
        begin
            pgMeta_reg <= powerGood;
            pgSync_reg <= pgMeta_reg;
        end
    end

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    // fixed single wait state, never longer
    assign waitrequest = (read | write) & ~ack_reg;

    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= (read | write) & ~ack_reg;
        end
    end

    // writes dropped while unpowered
    assign wrEn = write & ack_reg & byteenable[0] & pgSync_reg;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    function [7:0] readVal;
        input [7:0]  idx;
        input        fread;
        input [11:0] vx;
        input [11:0] vy;
        input [11:0] vz;
        input [7:0]  stat;
        input [7:0]  rng;
        input [7:0]  slp;
        input [7:0]  c1;
        input [7:0]  c2;
        begin
            readVal = 8'h00;
            if (fread)
            begin
                case (idx)
                    `ACCM_IDX_XMSB: readVal = vx[11:4];
                    `ACCM_IDX_XLSB: readVal = vy[11:4];
                    `ACCM_IDX_YMSB: readVal = vz[11:4];
                    default:        readVal = 8'h00;
                endcase
            end
            else
            begin
                case (idx)
                    `ACCM_IDX_XMSB: readVal = vx[11:4];
                    `ACCM_IDX_XLSB: readVal = {vx[3:0], 4'h0};
                    `ACCM_IDX_YMSB: readVal = vy[11:4];
                    `ACCM_IDX_YLSB: readVal = {vy[3:0], 4'h0};
                    `ACCM_IDX_ZMSB: readVal = vz[11:4];
                    `ACCM_IDX_ZLSB: readVal = {vz[3:0], 4'h0};
                    default:        readVal = 8'h00;
                endcase
            end
            case (idx)
                `ACCM_IDX_STAT:  readVal = stat;
                `ACCM_IDX_RANGE: readVal = rng;
                `ACCM_IDX_SLPTO: readVal = slp;
                `ACCM_IDX_CTRL1: readVal = c1;
                `ACCM_IDX_CTRL2: readVal = c2;
                default:         readVal = readVal;
            endcase
        end
    endfunction

    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            readdata <= 32'h0;
        end
        else if (read && !ack_reg)
        begin
            if (pgSync_reg)
            begin
                readdata <= {24'h0, readVal(regIdx, ctrl1_reg[`ACCM_FREAD_BIT],
                    outData_reg[0], outData_reg[1], outData_reg[2],
                    {6'h0, state_reg}, {6'h0, range_reg}, slpTo_reg,
                    {5'h0, ctrl1_reg},
                    {stEn_reg, 4'h0, slpEn_reg, 2'h0})};
            end
            else
            begin
                readdata <= 32'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            ctrl1_reg <= `ACCM_CTRL1_RST;
            slpEn_reg <= 1'b0;
            stEn_reg  <= 1'b0;
            range_reg <= `ACCM_RANGE_RST;
            slpTo_reg <= `ACCM_SLPTO_RST;
        end
        else if (!pgSync_reg)
        begin
            ctrl1_reg <= `ACCM_CTRL1_RST;
            slpEn_reg <= 1'b0;
            stEn_reg  <= 1'b0;
            range_reg <= `ACCM_RANGE_RST;
            slpTo_reg <= `ACCM_SLPTO_RST;
        end
        else if (wrEn)
        begin
            case (regIdx)
                `ACCM_IDX_CTRL1: ctrl1_reg <= writedata[2:0];
                `ACCM_IDX_CTRL2:
                begin
                    slpEn_reg <= writedata[`ACCM_SLPEN_BIT];
                    stEn_reg  <= writedata[`ACCM_STEN_BIT];
                end
                `ACCM_IDX_RANGE:
                begin
                    if (writedata[1:0] != 2'h3)
                    begin
                        range_reg <= writedata[1:0];
                    end
                end
                `ACCM_IDX_SLPTO: slpTo_reg <= writedata[7:0];
                default:         slpTo_reg <= slpTo_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // mode state machine
    // ----------------------------------------------------------------
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            `ACCM_ST_OFF:   state_next = `ACCM_ST_STBY;
            `ACCM_ST_STBY:
            begin
                if (ctrl1_reg[`ACCM_RUN_BIT])
                begin
                    state_next = `ACCM_ST_WAKE;
                end
            end
            `ACCM_ST_WAKE:
            begin
                if (!ctrl1_reg[`ACCM_RUN_BIT])
                begin
                    state_next = `ACCM_ST_STBY;
                end
                else if (slpEn_reg && (idle_reg >= slpTo_reg))
                begin
                    state_next = `ACCM_ST_SLEEP;
                end
            end
            `ACCM_ST_SLEEP:
            begin
                if (!ctrl1_reg[`ACCM_RUN_BIT])
                begin
                    state_next = `ACCM_ST_STBY;
                end
                else if (wakeEvent || !slpEn_reg)
                begin
                    state_next = `ACCM_ST_WAKE;
                end
            end
            default:        state_next = `ACCM_ST_OFF;
        endcase
        if (!pgSync_reg)
        begin
            state_next = `ACCM_ST_OFF;
        end
    end

    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            state_reg <= `ACCM_ST_OFF;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign active      = state_reg[1];
    assign enterActive = (state_reg == `ACCM_ST_STBY) && state_next[1];
    assign analogEn    = active;
    assign sampleClkEn = active;
    assign selfTestEn  = active & stEn_reg;
    assign modeState   = state_reg;

    // ----------------------------------------------------------------
    // sample-rate divider, runs only when active
    // ----------------------------------------------------------------
    assign divLimit = (state_reg == `ACCM_ST_SLEEP) ? SLEEP_DIV : WAKE_DIV;
    assign tick     = active && (div_reg == 16'h0);

    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            div_reg <= 16'h0;
        end
        else if (!active || (state_next != state_reg))
        begin
            div_reg <= 16'h0;
        end
        else if (tick)
        begin
            div_reg <= divLimit - 16'h1;
        end
        else
        begin
            div_reg <= div_reg - 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // idle timer for sleep entry
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            idle_reg <= 8'h0;
        end
        else if (enterActive || wakeEvent || (state_reg != `ACCM_ST_WAKE))
        begin
            idle_reg <= 8'h0;
        end
        else if (tick && (idle_reg != 8'hff))
        begin
            idle_reg <= idle_reg + 8'h1;
        end
    end

    // ----------------------------------------------------------------
    // axis formatting and output registers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : axis
            accm_axis_fmt u_fmt
            (
                .accelIn  (accelBus[16*g +: 16]),
                .stimIn   (stimBus[16*g +: 16]),
                .selfTest (stEn_reg),
                .quiet    (ctrl1_reg[`ACCM_QUIET_BIT]),
                .rangeSel (range_reg),
                .countOut (fmtBus[12*g +: 12])
            );
        end
    endgenerate

    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            for (i = 0; i < 3; i = i + 1)
            begin
                outData_reg[i] <= 12'h0;
            end
        end
        else if (!pgSync_reg || enterActive)
        begin
            for (i = 0; i < 3; i = i + 1)
            begin
                outData_reg[i] <= 12'h0;
            end
        end
        else if (tick)
        begin
            for (i = 0; i < 3; i = i + 1)
            begin
                outData_reg[i] <= fmtBus[12*i +: 12];
            end
        end
    end

    // standby holds output data and settings: only div_reg and idle_reg clear on leaving active

endmodule
`default_nettype wire

// File: bench/accm_mode_checker.sv
// Purpose: port-level assertions on accm_mode_ctrl
// Assumes: one clock, async active-low reset
// Notes:   bound to every accm_mode_ctrl instance
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// checker
// ------------------------------------------------
module accm_mode_checker
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        powerGood,
    input wire logic        analogEn,
    input wire logic        sampleClkEn,
    input wire logic        selfTestEn,
    input wire logic [1:0]  modeState
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_one_wait: assert property ((read | write) && waitrequest |=> !waitrequest)
        else $error("access stalled beyond one wait state");
    a_wait_first: assert property ($rose(read) |-> waitrequest)
        else $error("read answered without a wait state");
    a_off_dark: assert property (modeState == 2'h0 |-> !analogEn && !sampleClkEn)
        else $error("blocks running while off");
    a_power_drop: assert property ($fell(powerGood) |-> ##[1:4] modeState == 2'h0)
        else $error("no off state after power loss");
    a_stby_quiet: assert property (modeState == 2'h1 |-> !analogEn && !sampleClkEn && !selfTestEn)
        else $error("analog or clocks on in standby");
    a_active_on: assert property (modeState[1] |-> analogEn && sampleClkEn)
        else $error("active state without analog and clocks");
    a_sub_entry: assert property ($changed(modeState) && modeState[1] |-> $past(modeState) != 2'h0)
        else $error("sleep or wake entered from off");
    a_data_lane: assert property (readdata[31:8] == 24'h000000)
        else $error("read data upper lanes not zero");
    a_test_act: assert property (selfTestEn |-> modeState[1])
        else $error("self-test outside active");
endmodule
bind accm_mode_ctrl accm_mode_checker i_accm_mode_checker (.clk(clk), .reset_n(reset_n), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest), .powerGood(powerGood), .analogEn(analogEn),
    .sampleClkEn(sampleClkEn), .selfTestEn(selfTestEn), .modeState(modeState));
`default_nettype wire

// File: bench/accm_front_model.sv
// Purpose: sensing front end feeding the axis inputs
// Assumes: bench sets the physical values
// Notes:   unpowered outputs show inverted garbage
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// front end
// ------------------------------------------------
module accm_front_model
(
    input  wire logic        analogEn,
    input  wire logic [15:0] physX,
    input  wire logic [15:0] physY,
    input  wire logic [15:0] physZ,
    output logic      [15:0] accelX,
    output logic      [15:0] accelY,
    output logic      [15:0] accelZ
);
    assign accelX = analogEn ? physX : ~physX;
    assign accelY = analogEn ? physY : ~physY;
    assign accelZ = analogEn ? physZ : ~physZ;
endmodule
`default_nettype wire

// File: bench/accm_mode_ctrl_bench.sv
// Purpose: self-checking bench of accm_mode_ctrl
// Assumes: one wait state slave, short dividers
// Notes:   expectations computed from the axis rules
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// bench
// ------------------------------------------------
module accm_mode_ctrl_bench;
    logic        clk = 0, reset_n = 0, read = 0, write = 0, powerGood = 0, wakeEvent = 0;
    logic [9:0]  address = 0;
    logic [31:0] writedata = 0, readdata;
    logic [3:0]  byteenable = 4'hf;
    logic        waitrequest, analogEn, sampleClkEn, selfTestEn;
    logic [1:0]  modeState;
    logic [15:0] physX = 16'd1024, physY = -16'sd100, physZ = 0, stimX = 16'd200, stimY = 0, stimZ = 0;
    logic [15:0] accelX, accelY, accelZ;
    logic [7:0]  rd;
    integer      fails = 0, checks = 0, cyc = 0;
    initial forever #2.5 clk = ~clk;
    accm_front_model i_accm_front_model (.analogEn(analogEn), .physX(physX), .physY(physY), .physZ(physZ),
        .accelX(accelX), .accelY(accelY), .accelZ(accelZ));
    accm_mode_ctrl #(.WAKE_DIV(16'd4), .SLEEP_DIV(16'd8)) i_accm_mode_ctrl (.clk(clk), .reset_n(reset_n),
        .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .powerGood(powerGood), .accelX(accelX),
        .accelY(accelY), .accelZ(accelZ), .stimX(stimX), .stimY(stimY), .stimZ(stimZ),
        .wakeEvent(wakeEvent), .analogEn(analogEn), .sampleClkEn(sampleClkEn), .selfTestEn(selfTestEn),
        .modeState(modeState));
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            summarize();
        end
    end
    task summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task bus_wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk);
        address <= {idx, 2'h0};
        writedata <= {24'h000000, d};
        byteenable <= be;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask
    task bus_rd(input logic [7:0] idx, output logic [7:0] d);
        @(posedge clk);
        address <= {idx, 2'h0};
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata[7:0];
        read <= 1'b0;
    endtask
    task cycles(input integer n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [11:0] exp12(input logic [15:0] a, input logic [15:0] b, input bit st,
        input bit q, input int r);
        int s;
        s = $signed(a) + (st ? $signed(b) : 0);
        if (q && s > 4095) s = 4095;
        if (q && s < -4096) s = -4096;
        s = s >>> r;
        if (s > 2047) s = 2047;
        if (s < -2048) s = -2048;
        return s[11:0];
    endfunction
    task chk_axis(input logic [7:0] idx, input logic [11:0] e);
        bus_rd(idx, rd);
        chk(rd, e[11:4]);
        bus_rd(idx + 8'h01, rd);
        chk(rd, {e[3:0], 4'h0});
    endtask
    task t_standby();
        bus_rd(8'h0b, rd);
        chk(rd[1:0], 2'h1);
        chk(analogEn, 1'b0);
        chk(sampleClkEn, 1'b0);
        bus_rd(8'h3f, rd);
        chk(rd, 8'h00);
    endtask
    task t_scale();
        for (int r = 0; r < 3; r++)
        begin
            bus_wr(8'h0e, r[7:0], 4'hf);
            bus_wr(8'h2a, 8'h01, 4'hf);
            cycles(12);
            chk(modeState[1], 1'b1);
            chk(sampleClkEn, 1'b1);
            chk_axis(8'h00, exp12(physX, 0, 0, 0, r));
            chk_axis(8'h02, exp12(physY, 0, 0, 0, r));
            chk_axis(8'h04, 12'h000);
            bus_wr(8'h2a, 8'h00, 4'hf);
            cycles(4);
            chk(modeState, 2'h1);
            chk_axis(8'h00, exp12(physX, 0, 0, 0, r));
            bus_rd(8'h0e, rd);
            chk(rd, r[7:0]);
        end
    endtask
    task t_selftest_quiet();
        bus_wr(8'h0e, 8'h00, 4'hf);
        bus_wr(8'h2b, 8'h80, 4'hf);
        bus_wr(8'h2a, 8'h01, 4'hf);
        cycles(12);
        chk(selfTestEn, 1'b1);
        chk_axis(8'h00, exp12(physX, stimX, 1, 0, 0));
        bus_wr(8'h2a, 8'h00, 4'hf);
        bus_wr(8'h2b, 8'h00, 4'hf);
        physX <= 16'd6000;
        bus_wr(8'h0e, 8'h02, 4'hf);
        bus_wr(8'h2a, 8'h05, 4'hf);
        cycles(12);
        chk_axis(8'h00, exp12(16'd6000, 0, 0, 1, 2));
        bus_wr(8'h2a, 8'h01, 4'hf);
        cycles(12);
        chk_axis(8'h00, exp12(16'd6000, 0, 0, 0, 2));
        bus_wr(8'h2a, 8'h00, 4'hf);
    endtask
    task t_fastread();
        bus_wr(8'h2a, 8'h03, 4'hf);
        cycles(12);
        bus_rd(8'h01, rd);
        chk(rd, exp12(physY, 0, 0, 0, 2) >> 4);
        bus_rd(8'h03, rd);
        chk(rd, 8'h00);
        bus_wr(8'h2a, 8'h00, 4'hf);
    endtask
    task t_sleep();
        int n;
        bus_wr(8'h29, 8'h02, 4'hf);
        bus_wr(8'h2b, 8'h04, 4'hf);
        bus_wr(8'h2a, 8'h01, 4'hf);
        n = 0;
        while (modeState !== 2'h3 && n < 300)
        begin
            @(posedge clk);
            n = n + 1;
        end
        chk(modeState, 2'h3);
        wakeEvent <= 1'b1;
        cycles(3);
        chk(modeState, 2'h2);
        wakeEvent <= 1'b0;
        bus_wr(8'h2a, 8'h00, 4'hf);
        cycles(3);
        chk(modeState, 2'h1);
        bus_wr(8'h2b, 8'h00, 4'hf);
    endtask
    task t_power();
        bus_wr(8'h0e, 8'h01, 4'h0);
        bus_rd(8'h0e, rd);
        chk(rd, 8'h02);
        bus_wr(8'h0e, 8'h03, 4'hf);
        bus_rd(8'h0e, rd);
        chk(rd, 8'h02);
        powerGood <= 1'b0;
        cycles(6);
        chk(modeState, 2'h0);
        chk(analogEn, 1'b0);
        bus_rd(8'h0e, rd);
        chk(rd, 8'h00);
        bus_wr(8'h0e, 8'h01, 4'hf);
        powerGood <= 1'b1;
        cycles(6);
        bus_rd(8'h0e, rd);
        chk(rd, 8'h00);
    endtask
    initial
    begin
        cycles(10);
        reset_n <= 1'b1;
        cycles(4);
        powerGood <= 1'b1;
        cycles(8);
        t_standby();
        t_scale();
        t_selftest_quiet();
        t_fastread();
        t_sleep();
        t_power();
        summarize();
    end
endmodule
`default_nettype wire
